// >>> rtl/cfr_top.sv
// Overcurrent and undercurrent fault response and retry sequencer, one per page.
// Assumes fault levels, on commands and bias are synchronous to clock.
`include "cfr_defines.svh"

module cfr_top
#(
    parameter int          NUM_PAGES   = `CFR_NUM_PAGES,
    parameter int          PW          = (NUM_PAGES > 1) ? $clog2(NUM_PAGES) : 1,
    parameter int unsigned TICK_CYCLES = `CFR_TICK_CYCLES
)
(
    input  logic                                     clock,
    input  logic                                     arst_n,
    input  logic                                     ce,
    input  cfr_pkg::cfr_cmd_t                        cmd,
    input  logic [PW-1:0]                            cmd_page,
    output cfr_pkg::cfr_rsp_t                        rsp,
    input  logic                                     bias_ok,
    input  cfr_pkg::cfr_page_in_t  [NUM_PAGES-1:0]   page_in,
    output cfr_pkg::cfr_page_out_t [NUM_PAGES-1:0]   page_out,
    output logic                                     alert_out_n
);

    typedef struct packed
    {
        cfr_pkg::cfr_page_t [NUM_PAGES-1:0] page;
        logic                               rsp_valid;
        logic                               rsp_unsup;
        logic                               alert_n;
    } cfr_regs_t;

    logic                           rst_meta;
    logic                           rst_n;
    logic                           clear_req;
    logic                           resp_cmd;
    logic                           page_ok;
    logic                           mem_wr;
    logic                           mem_rd;
    logic                           mem_sel;
    logic [7:0]                     mem_rdata;
    logic [NUM_PAGES-1:0][1:0][7:0] cfg;
    cfr_regs_t                      q;
    cfr_regs_t                      next_q;

    // Anything but the while-fault mode or continuous retry falls back to a latched shutdown, the safe side
    function automatic cfr_pkg::cfr_mode_t react(input logic [7:0] resp);
        cfr_pkg::cfr_mode_t m;
        m = cfr_pkg::CFR_HOLD;
        if (resp[`CFR_MODE_HI:`CFR_MODE_LO] == `CFR_MODE_WHILE)
            m = cfr_pkg::CFR_WAIT;
        else if (resp[`CFR_RETRY_HI:`CFR_RETRY_LO] == `CFR_RETRY_CONT)
            m = cfr_pkg::CFR_RETRY;
        return m;
    endfunction

    // Last count of one retry interval
    function automatic logic [`CFR_CNT_W-1:0] retry_last(input logic [2:0] d);
        logic [31:0] p;
        p = (32'(d) + 32'h1) * 32'(TICK_CYCLES) - 32'h1;
        return p[`CFR_CNT_W-1:0];
    endfunction

    assign resp_cmd  = (cmd.code == `CFR_CMD_OC_RESP) || (cmd.code == `CFR_CMD_UC_RESP);
    assign page_ok   = int'(cmd_page) < NUM_PAGES;
    assign clear_req = cmd.valid && cmd.write && (cmd.code == `CFR_CMD_CLEAR_FAULTS);
    assign mem_wr    = cmd.valid && cmd.write && resp_cmd && page_ok;
    assign mem_rd    = cmd.valid && !cmd.write && resp_cmd && page_ok;
    assign mem_sel   = cmd.code == `CFR_CMD_UC_RESP;

    cfr_regmem
    #(
        .NUM_PAGES (NUM_PAGES),
        .PW        (PW)
    )
    u_mem
    (
        .clock (clock),
        .rst_n (rst_n),
        .ce    (ce),
        .wr_en (mem_wr),
        .rd_en (mem_rd),
        .sel   (mem_sel),
        .page  (cmd_page),
        .wdata (cmd.wdata),
        .rdata (mem_rdata),
        .cfg   (cfg)
    );

    always_comb
    begin
        logic       go;
        logic       hit_oc;
        logic       hit_uc;
        logic       any_stat;
        logic [7:0] resp;
        go       = 1'b0;
        hit_oc   = 1'b0;
        hit_uc   = 1'b0;
        any_stat = 1'b0;
        resp     = 8'h00;
        next_q   = q;
        if (ce)
        begin
            for (int i = 0; i < NUM_PAGES; i++)
            begin
                go     = bias_ok && page_in[i].on_cmd && !page_in[i].shutdown_req;
                hit_oc = page_in[i].oc_fault;
                hit_uc = page_in[i].uc_fault;
                // Overcurrent wins when both faults arrive together
                resp   = hit_oc ? cfg[i][0] : cfg[i][1];
                // Set wins over clear so no fault is lost
                next_q.page[i].oc_stat = hit_oc || (q.page[i].oc_stat && !clear_req);
                next_q.page[i].uc_stat = hit_uc || (q.page[i].uc_stat && !clear_req);
                case (q.page[i].mode)
                    cfr_pkg::CFR_OFF:
                    begin
                        if (go)
                            next_q.page[i].mode = cfr_pkg::CFR_RUN;
                    end
                    cfr_pkg::CFR_RUN:
                    begin
                        if (hit_oc || hit_uc)
                        begin
                            next_q.page[i].mode  = react(resp);
                            next_q.page[i].cnt   = '0;
                            next_q.page[i].delay = resp[`CFR_DELAY_HI:`CFR_DELAY_LO];
                        end
                    end
                    cfr_pkg::CFR_HOLD:
                    begin
                        if (clear_req)
                            next_q.page[i].mode = cfr_pkg::CFR_OFF;
                    end
                    cfr_pkg::CFR_WAIT:
                    begin
                        if (!hit_oc && !hit_uc)
                            next_q.page[i].mode = cfr_pkg::CFR_RUN;
                    end
                    cfr_pkg::CFR_RETRY:
                    begin
                        // No fault check before an attempt
                        if (q.page[i].cnt == retry_last(q.page[i].delay))
                        begin
                            next_q.page[i].mode = cfr_pkg::CFR_TRY;
                            next_q.page[i].cnt  = '0;
                        end
                        else
                            next_q.page[i].cnt = q.page[i].cnt + 1'b1;
                    end
                    cfr_pkg::CFR_TRY:
                    begin
                        // Counter keeps running so the next start stays on the grid
                        if (hit_oc || hit_uc)
                        begin
                            next_q.page[i].mode = cfr_pkg::CFR_RETRY;
                            if (q.page[i].cnt == retry_last(q.page[i].delay))
                                next_q.page[i].cnt = '0;
                            else
                                next_q.page[i].cnt = q.page[i].cnt + 1'b1;
                        end
                        else if (q.page[i].cnt == retry_last(q.page[i].delay))
                            next_q.page[i].mode = cfr_pkg::CFR_RUN;
                        else
                            next_q.page[i].cnt = q.page[i].cnt + 1'b1;
                    end
                    default:
                    begin
                        next_q.page[i].mode = cfr_pkg::CFR_OFF;
                    end
                endcase
                if (!go)
                begin
                    next_q.page[i].mode = cfr_pkg::CFR_OFF;
                    next_q.page[i].cnt  = '0;
                end
                next_q.page[i].en = (next_q.page[i].mode == cfr_pkg::CFR_RUN)
                                 || (next_q.page[i].mode == cfr_pkg::CFR_TRY);
                any_stat = any_stat || next_q.page[i].oc_stat || next_q.page[i].uc_stat;
            end
            next_q.alert_n   = !any_stat;
            next_q.rsp_valid = cmd.valid && !cmd.write;
            next_q.rsp_unsup = cmd.valid && !cmd.write && !(resp_cmd && page_ok);
        end
    end

    // Reset sync runs regardless of clock enable
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q         <= '0;
            q.alert_n <= 1'b1;
        end
        else
            q <= next_q;
    end

    always_comb
    begin
        for (int i = 0; i < NUM_PAGES; i++)
        begin
            page_out[i].out_en  = q.page[i].en;
            page_out[i].oc_stat = q.page[i].oc_stat;
            page_out[i].uc_stat = q.page[i].uc_stat;
        end
    end

    assign rsp.valid       = q.rsp_valid;
    assign rsp.unsupported = q.rsp_unsup;
    assign rsp.data        = mem_rdata;
    assign alert_out_n     = q.alert_n;

    alert_low_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        ce && (page_in[0].oc_fault || page_in[0].uc_fault) |=> !alert_out_n)
        else $error("alert not asserted on current fault");

    stat_set_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        ce && page_in[0].oc_fault && clear_req |=> page_out[0].oc_stat)
        else $error("fault lost against clear");

    stat_hold_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        page_out[0].oc_stat && !clear_req |=> page_out[0].oc_stat)
        else $error("status cleared without clear command");

    oc_any_cfg_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        ce && page_in[0].oc_fault && !page_in[0].uc_fault && !page_out[0].uc_stat
        |=> page_out[0].oc_stat && !page_out[0].uc_stat)
        else $error("overcurrent status missing");

    uc_set_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        ce && page_in[0].uc_fault |=> page_out[0].uc_stat)
        else $error("undercurrent status missing");

    off_now_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        ce && q.page[0].mode == cfr_pkg::CFR_RUN && page_in[0].oc_fault
        && cfg[0][0][`CFR_MODE_HI:`CFR_MODE_LO] == `CFR_MODE_LATCH
        |=> !page_out[0].out_en)
        else $error("output not disabled at once");

    wait_back_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        ce && q.page[0].mode == cfr_pkg::CFR_WAIT && bias_ok && page_in[0].on_cmd
        && !page_in[0].shutdown_req && !page_in[0].oc_fault && !page_in[0].uc_fault
        |=> page_out[0].out_en)
        else $error("output not resumed after fault");

    hold_off_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        q.page[0].mode == cfr_pkg::CFR_HOLD && !clear_req
        |=> !page_out[0].out_en [*2])
        else $error("latched output restarted");

    attempt_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        ce && q.page[0].mode == cfr_pkg::CFR_RETRY && bias_ok && page_in[0].on_cmd
        && !page_in[0].shutdown_req && q.page[0].cnt == retry_last(q.page[0].delay)
        |=> page_out[0].out_en && q.page[0].cnt == '0)
        else $error("restart attempt missed");

    stop_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        ce && (!bias_ok || !page_in[0].on_cmd || page_in[0].shutdown_req)
        |=> !page_out[0].out_en && q.page[0].mode == cfr_pkg::CFR_OFF)
        else $error("retry not stopped");

    cnt_grid_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        ce && q.page[0].mode == cfr_pkg::CFR_TRY && page_in[0].oc_fault && bias_ok
        && page_in[0].on_cmd && !page_in[0].shutdown_req
        && q.page[0].cnt != retry_last(q.page[0].delay)
        |=> q.page[0].cnt == $past(q.page[0].cnt) + 1'b1)
        else $error("retry interval restarted");

    reg_wr_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        ce && mem_wr && cmd_page == '0 && !mem_sel |=> cfg[0][0] == $past(cmd.wdata))
        else $error("response setting not stored");

    cover_retry_c: cover property (@(posedge clock) disable iff (!rst_n)
        q.page[0].mode == cfr_pkg::CFR_RETRY ##1 q.page[0].mode == cfr_pkg::CFR_TRY);
    cover_wait_c: cover property (@(posedge clock) disable iff (!rst_n)
        q.page[0].mode == cfr_pkg::CFR_WAIT ##1 q.page[0].mode == cfr_pkg::CFR_RUN);
    cover_hold_c: cover property (@(posedge clock) disable iff (!rst_n)
        q.page[0].mode == cfr_pkg::CFR_HOLD ##1 q.page[0].mode == cfr_pkg::CFR_OFF);
    cover_clear_c: cover property (@(posedge clock) disable iff (!rst_n)
        !alert_out_n ##1 alert_out_n);

endmodule

// >>> rtl/cfr_defines.svh
// Command codes, field positions, reset values and timing of the fault response block.
// Assumes inclusion by bare name from every file that needs a constant.
`ifndef CFR_DEFINES_SVH
`define CFR_DEFINES_SVH

`define CFR_CMD_CLEAR_FAULTS 8'h03
`define CFR_CMD_OC_RESP      8'hE5
`define CFR_CMD_UC_RESP      8'hE6
`define CFR_RESP_RESET       8'h80

`define CFR_MODE_HI          7
`define CFR_MODE_LO          6
`define CFR_RETRY_HI         5
`define CFR_RETRY_LO         3
`define CFR_DELAY_HI         2
`define CFR_DELAY_LO         0

`define CFR_MODE_LATCH       2'h2
`define CFR_MODE_WHILE       2'h3
`define CFR_RETRY_NONE       3'h0
`define CFR_RETRY_CONT       3'h7

`define CFR_RETRY_UNIT_MS    35
`define CFR_CLK_KHZ          50000
`define CFR_TICK_CYCLES      (`CFR_RETRY_UNIT_MS * `CFR_CLK_KHZ)
`define CFR_CNT_W            24
`define CFR_NUM_PAGES        2

`endif

// >>> rtl/cfr_pkg.sv
// Types shared by the fault response block, its host model and its bench.
// Assumes the defines header is available on the include path.
`include "cfr_defines.svh"

package cfr_pkg;

    typedef enum logic [2:0]
    {
        CFR_OFF,
        CFR_RUN,
        CFR_HOLD,
        CFR_WAIT,
        CFR_RETRY,
        CFR_TRY
    } cfr_mode_t;

    typedef struct packed
    {
        cfr_mode_t              mode;
        logic [`CFR_CNT_W-1:0]  cnt;
        logic [2:0]             delay;
        logic                   oc_stat;
        logic                   uc_stat;
        logic                   en;
    } cfr_page_t;

    typedef struct packed
    {
        logic       valid;
        logic       write;
        logic [7:0] code;
        logic [7:0] wdata;
    } cfr_cmd_t;

    typedef struct packed
    {
        logic       valid;
        logic       unsupported;
        logic [7:0] data;
    } cfr_rsp_t;

    typedef struct packed
    {
        logic oc_fault;
        logic uc_fault;
        logic on_cmd;
        logic shutdown_req;
    } cfr_page_in_t;

    typedef struct packed
    {
        logic out_en;
        logic oc_stat;
        logic uc_stat;
    } cfr_page_out_t;

endpackage

// >>> rtl/cfr_regmem.sv
// Paged byte store for the overcurrent and undercurrent response settings.
// Assumes strobes are already decoded and the page index is in range.
`include "cfr_defines.svh"

module cfr_regmem
#(
    parameter int NUM_PAGES = `CFR_NUM_PAGES,
    parameter int PW        = 1
)
(
    input  logic                           clock,
    input  logic                           rst_n,
    input  logic                           ce,
    input  logic                           wr_en,
    input  logic                           rd_en,
    input  logic                           sel,
    input  logic [PW-1:0]                  page,
    input  logic [7:0]                     wdata,
    output logic [7:0]                     rdata,
    output logic [NUM_PAGES-1:0][1:0][7:0] cfg
);

    typedef struct packed
    {
        logic [NUM_PAGES-1:0][1:0][7:0] mem;
        logic [7:0]                     rdata;
    } cfr_mem_t;

    cfr_mem_t q;
    cfr_mem_t next_q;

    always_comb
    begin
        next_q = q;
        if (ce)
        begin
            // Unmapped reads answer zero
            next_q.rdata = rd_en ? q.mem[page][sel] : 8'h00;
            if (wr_en)
                next_q.mem[page][sel] = wdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            q <= {{(NUM_PAGES * 2){`CFR_RESP_RESET}}, 8'h00};
        else
            q <= next_q;
    end

    assign rdata = q.rdata;
    assign cfg   = q.mem;

endmodule

// >>> tb/cfr_host.sv
// Host model that issues byte commands to the fault response block.
// Assumes a free-running clock and a read answer registered one cycle late.
`include "cfr_defines.svh"

module cfr_host
(
    input  logic              clock,
    output cfr_pkg::cfr_cmd_t cmd,
    output logic              cmd_page,
    input  cfr_pkg::cfr_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        cmd      = '0;
        cmd_page = 1'b0;
    end

    // Standard fault response byte layout, one byte per command
    task automatic xfer(input logic wr, input logic [7:0] code, input logic pg,
                        input logic [7:0] wd, output cfr_pkg::cfr_rsp_t r);
        @(posedge clock);
        cmd      <= {1'b1, wr, code, wd};
        cmd_page <= pg;
        @(posedge clock);
        // Idle fields scrambled so a stale value never passes for a live one
        cmd      <= {1'b0, ~wr, ~code, ~wd};
        cmd_page <= ~pg;
        #1;
        r = rsp;
    endtask
endmodule

// >>> tb/cfr_top_tb.sv
// Self-checking bench for the current fault response block.
// Assumes the host model drives commands and the bench drives fault levels.
`include "cfr_defines.svh"

module cfr_top_tb;
    timeunit 1ns;
    timeprecision 1ns;

    // Short retry unit keeps the run brief
    localparam int TICK = 4;

    logic                         clock;
    logic                         arst_n;
    logic                         ce;
    logic                         bias_ok;
    logic                         alert_out_n;
    logic                         cmd_page;
    cfr_pkg::cfr_cmd_t            cmd;
    cfr_pkg::cfr_rsp_t            rsp;
    cfr_pkg::cfr_rsp_t            r;
    cfr_pkg::cfr_page_in_t  [1:0] page_in;
    cfr_pkg::cfr_page_out_t [1:0] page_out;
    int                           error_cnt;
    int                           tests_run;
    int                           n;
    logic [7:0]                   d;
    logic [7:0]                   code;
    logic [7:0]                   v;
    logic                         any_on;
    logic [3:0][7:0]              shadow;

    cfr_top #(.NUM_PAGES(2), .PW(1), .TICK_CYCLES(TICK)) i_cfr_top
    (
        .clock       (clock),
        .arst_n      (arst_n),
        .ce          (ce),
        .cmd         (cmd),
        .cmd_page    (cmd_page),
        .rsp         (rsp),
        .bias_ok     (bias_ok),
        .page_in     (page_in),
        .page_out    (page_out),
        .alert_out_n (alert_out_n)
    );

    cfr_host i_cfr_host (.clock(clock), .cmd(cmd), .cmd_page(cmd_page), .rsp(rsp));

    always #10 clock = ~clock;

    function automatic int exp_interval(input logic [2:0] dl);
        return (int'(dl) + 1) * TICK;
    endfunction

    // Only the defined response and retry encodings
    function automatic logic [7:0] resp_byte(input logic [31:0] x);
        return {1'b1, x[3], {3{x[4]}}, x[2:0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic reg_read(input logic pg, input logic [7:0] cd, input logic [7:0] exp);
        i_cfr_host.xfer(1'b0, cd, pg, 8'h00, r);
        check(r.valid, 1'b1);
        check(r.data, exp);
    endtask

    task automatic clear_faults();
        i_cfr_host.xfer(1'b1, `CFR_CMD_CLEAR_FAULTS, 1'b0, 8'h00, r);
    endtask

    task automatic next_rise(output int cnt);
        logic prev;
        prev = page_out[0].out_en;
        cnt  = 0;
        repeat (2000)
        begin
            @(posedge clock);
            #1;
            cnt++;
            if (!prev && page_out[0].out_en === 1'b1)
                break;
            prev = page_out[0].out_en;
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (30000) @(posedge clock);
        error_cnt++;
        end_of_test();
    end

    initial
    begin
        clock     = 1'b0;
        arst_n    = 1'b0;
        ce        = 1'b1;
        bias_ok   = 1'b1;
        page_in   = 8'h22;
        error_cnt = 0;
        tests_run = 0;
        void'($urandom(32'hEF1C));
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        repeat (6) @(posedge clock);
        #1;
        for (int p = 0; p < 2; p++)
        begin
            reg_read(p[0], `CFR_CMD_OC_RESP, `CFR_RESP_RESET);
            reg_read(p[0], `CFR_CMD_UC_RESP, `CFR_RESP_RESET);
        end
        i_cfr_host.xfer(1'b0, 8'h20, 1'b0, 8'h00, r);
        check({r.unsupported, r.data}, 9'h100);
        check({page_out[1].out_en, page_out[0].out_en, alert_out_n}, 3'h7);
        $display("Test reset values done");

        shadow = {4{`CFR_RESP_RESET}};
        for (int i = 0; i < 8; i++)
        begin
            v    = resp_byte($urandom);
            code = ($urandom % 2) ? `CFR_CMD_OC_RESP : `CFR_CMD_UC_RESP;
            i_cfr_host.xfer(1'b1, code, i[0], v, r);
            shadow[{i[0], code == `CFR_CMD_UC_RESP}] = v;
            reg_read(i[0], code, v);
        end
        // Unknown code writes must leave every page untouched
        i_cfr_host.xfer(1'b1, 8'h20, 1'b0, 8'h5A, r);
        for (int k = 0; k < 4; k++)
            reg_read(k[1], k[0] ? `CFR_CMD_UC_RESP : `CFR_CMD_OC_RESP, shadow[k]);
        i_cfr_host.xfer(1'b1, `CFR_CMD_OC_RESP, 1'b0, `CFR_RESP_RESET, r);
        @(posedge clock);
        ce <= 1'b0;
        i_cfr_host.xfer(1'b1, `CFR_CMD_OC_RESP, 1'b0, 8'hBF, r);
        @(posedge clock);
        ce <= 1'b1;
        reg_read(1'b0, `CFR_CMD_OC_RESP, `CFR_RESP_RESET);
        $display("Test register access done");

        @(posedge clock);
        page_in[0].oc_fault <= 1'b1;
        @(posedge clock);
        page_in[0].oc_fault <= 1'b0;
        @(posedge clock);
        #1;
        check({page_out[0].oc_stat, page_out[0].uc_stat, alert_out_n}, 3'h4);
        check(page_out[0].out_en, 1'b0);
        repeat (40) @(posedge clock);
        #1;
        check({page_out[0].out_en, page_out[0].oc_stat}, 2'h1);
        check(alert_out_n, 1'b0);
        clear_faults();
        repeat (4) @(posedge clock);
        #1;
        check({page_out[0].out_en, page_out[0].oc_stat, alert_out_n}, 3'h5);
        $display("Test latched shutdown done");

        // Both faults at once: overcurrent setting wins, clear during fault is lost
        i_cfr_host.xfer(1'b1, `CFR_CMD_UC_RESP, 1'b0, 8'hC0, r);
        @(posedge clock);
        page_in[0].oc_fault <= 1'b1;
        page_in[0].uc_fault <= 1'b1;
        clear_faults();
        repeat (4) @(posedge clock);
        page_in[0].oc_fault <= 1'b0;
        page_in[0].uc_fault <= 1'b0;
        repeat (4) @(posedge clock);
        #1;
        check({page_out[0].oc_stat, page_out[0].uc_stat, alert_out_n}, 3'h6);
        check(page_out[0].out_en, 1'b0);
        clear_faults();
        repeat (4) @(posedge clock);
        #1;
        check({page_out[0].out_en, page_out[0].uc_stat, alert_out_n}, 3'h5);
        $display("Test paired faults done");

        i_cfr_host.xfer(1'b1, `CFR_CMD_UC_RESP, 1'b1, 8'hC0, r);
        @(posedge clock);
        page_in[1].uc_fault <= 1'b1;
        repeat (10) @(posedge clock);
        #1;
        check({page_out[1].out_en, page_out[1].uc_stat, page_out[1].oc_stat}, 3'h2);
        check({page_out[0].out_en, alert_out_n}, 2'h2);
        @(posedge clock);
        page_in[1].uc_fault <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
        check({page_out[1].out_en, page_out[1].uc_stat}, 2'h3);
        clear_faults();
        repeat (2) @(posedge clock);
        #1;
        check({page_out[1].uc_stat, alert_out_n}, 2'h1);
        $display("Test hold while fault done");

        for (int i = 0; i < 3; i++)
        begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'h07 : 8'($urandom % 8);
            i_cfr_host.xfer(1'b1, `CFR_CMD_OC_RESP, 1'b0, {5'b10111, d[2:0]}, r);
            @(posedge clock);
            page_in[0].oc_fault <= 1'b1;
            next_rise(n);
            next_rise(n);
            check(n, exp_interval(d[2:0]));
            @(posedge clock);
            case (i)
                0: page_in[0].on_cmd <= 1'b0;
                1: bias_ok <= 1'b0;
                default: page_in[0].shutdown_req <= 1'b1;
            endcase
            any_on = 1'b0;
            repeat (3) @(posedge clock);
            repeat (2 * exp_interval(d[2:0]) + 8)
            begin
                @(posedge clock);
                #1;
                any_on = any_on | page_out[0].out_en;
            end
            check(any_on, 1'b0);
            @(posedge clock);
            page_in[0] <= 4'h2;
            bias_ok    <= 1'b1;
            clear_faults();
            repeat (4) @(posedge clock);
            #1;
            check({page_out[0].out_en, page_out[0].oc_stat}, 2'h2);
        end
        $display("Test continuous retry done");

        // Mid-run reset must bring the undercurrent setting of both pages back to its default
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        repeat (6) @(posedge clock);
        #1;
        check({page_out[0].out_en, page_out[0].oc_stat, alert_out_n}, 3'h5);
        reg_read(1'b0, `CFR_CMD_UC_RESP, `CFR_RESP_RESET);
        reg_read(1'b1, `CFR_CMD_UC_RESP, `CFR_RESP_RESET);
        $display("Test mid-run reset done");
        end_of_test();
    end
endmodule
